/* File: core/sab_regs.sv */
// auto-copy control, message gap and read-only status registers
// Summary of operation
// - The gap between user-data messages is the 16-bit count from the high and low gap bytes.
// - After reset the gap bytes hold 0x00 and 0x09, a nine-zero message gap.
// - Unit stuffing enable lets zeros go between units; clear leaves unit spacing unchanged.
// - User-bit auto copy moves received user bits to the transmitter only while set.
// - Channel-status auto copy moves received status bits to the transmitter only while set.
// - The 4-bit unit gap limit is plain binary from zero up to eight.
// - The 15-bit converter ratio reads as bits 14:8 in 0x12 (bit 7 zero) and 7:0 in 0x13.
// - Ratio and preamble registers are read only and ignore writes.
// - A detected burst captures preamble C, upper byte at 0x14 and lower at 0x15.
// - A detected burst captures preamble D, upper byte at 0x16 and lower at 0x17.
// - With no nonaudio data detected every preamble register reads zero.
// - Under subframe nonaudio the D pair holds channel B's preamble C.
// - Unit stuffing applies only when the transmit user-buffer mode is the unit format.
`timescale 1ns/10ps
`default_nettype none

module sab_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      count_next;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid  = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
    end else begin
      // ready is registered so the receiver side sees a flop, not a compare
      in_ready <= (count_next != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
    end
  end
endmodule // sab_fifo

module sab_regs
  import sab_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port behind the serial control interface
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // transmitter configuration
  input  wire logic [1:0]  tx_user_buffer_mode,
  // received user bits
  input  wire logic        rx_user_valid,
  output logic             rx_user_ready,
  input  wire logic        rx_user_bit,
  input  wire logic        rx_msg_start,
  input  wire logic        rx_unit_start,
  // transmitted user bits
  input  wire logic        tx_user_req,
  output logic             tx_user_valid,
  output logic             tx_user_bit,
  // channel status copy
  input  wire logic        rx_cs_valid,
  input  wire logic        rx_cs_bit,
  output logic             tx_cs_valid,
  output logic             tx_cs_bit,
  // measured status
  input  wire logic [14:0] converter_ratio,
  input  wire logic        nonaudio_present,
  input  wire logic        burst_detect,
  input  wire logic        subframe_nonaudio,
  input  wire logic [15:0] burst_pre_c,
  input  wire logic [15:0] burst_pre_d,
  input  wire logic [15:0] burst_pre_c_b
);
  logic [7:0]       message_gap_high_reg;
  logic [7:0]       message_gap_low_reg;
  logic             unit_stuffing_enable_reg;
  logic             user_bit_auto_copy_reg;
  logic             channel_status_auto_copy_reg;
  logic [3:0]       unit_gap_limit_reg;
  logic [14:0]      ratio_reg;
  logic [15:0]      pre_c_reg;
  logic [15:0]      pre_d_reg;
  logic [15:0]      gap_cnt_reg;
  logic             head_gapped_reg;
  sab_state_e       state_reg;
  logic             ub_out_valid;
  logic             ub_out_ready;
  logic [UB_WIDTH-1:0] ub_out_data;
  logic [15:0]      msg_gap;
  logic             units_active;
  logic             needs_gap;
  logic [15:0]      load_val;
  logic             wr_hit;

  function automatic logic [3:0] clamp_limit(input logic [3:0] v);
    return (v > LIMIT_MAX) ? LIMIT_MAX : v;
  endfunction

  // register writes
  assign wr_hit = reg_wr && rst_n;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      message_gap_high_reg <= RST_GAP_HIGH;
      message_gap_low_reg  <= RST_GAP_LOW;
    end else if (wr_hit && reg_addr == OFS_GAP_HIGH) begin
      message_gap_high_reg <= reg_wdata;
    end else if (wr_hit && reg_addr == OFS_GAP_LOW) begin
      message_gap_low_reg <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unit_stuffing_enable_reg     <= RST_AUTO_COPY[BIT_UNIT_STUFF];
      user_bit_auto_copy_reg       <= RST_AUTO_COPY[BIT_USER_COPY];
      channel_status_auto_copy_reg <= RST_AUTO_COPY[BIT_CS_COPY];
      unit_gap_limit_reg           <= RST_AUTO_COPY[LIMIT_MSB:0];
    end else if (wr_hit && reg_addr == OFS_AUTO_COPY) begin
      unit_stuffing_enable_reg     <= reg_wdata[BIT_UNIT_STUFF];
      user_bit_auto_copy_reg       <= reg_wdata[BIT_USER_COPY];
      channel_status_auto_copy_reg <= reg_wdata[BIT_CS_COPY];
      unit_gap_limit_reg           <= clamp_limit(reg_wdata[LIMIT_MSB:0]);
    end
  end

  // read-only status
  // ratio tracked every cycle, preambles loaded on a burst or cleared; no write path reaches these
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ratio_reg <= '0;
    end else begin
      ratio_reg <= converter_ratio;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pre_c_reg <= '0;
      pre_d_reg <= '0;
    end else if (!nonaudio_present) begin
      pre_c_reg <= '0;
      pre_d_reg <= '0;
    end else if (burst_detect) begin
      pre_c_reg <= burst_pre_c;
      pre_d_reg <= subframe_nonaudio ? burst_pre_c_b : burst_pre_d;
    end
  end

  // register reads
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          OFS_GAP_HIGH:   reg_rdata <= message_gap_high_reg;
          OFS_GAP_LOW:    reg_rdata <= message_gap_low_reg;
          OFS_AUTO_COPY:  reg_rdata <= {1'b0, unit_stuffing_enable_reg, user_bit_auto_copy_reg,
                                        channel_status_auto_copy_reg, unit_gap_limit_reg};
          OFS_RATIO_HIGH: reg_rdata <= {1'b0, ratio_reg[14:8]};
          OFS_RATIO_LOW:  reg_rdata <= ratio_reg[7:0];
          OFS_PRE_C_HIGH: reg_rdata <= pre_c_reg[15:8];
          OFS_PRE_C_LOW:  reg_rdata <= pre_c_reg[7:0];
          OFS_PRE_D_HIGH: reg_rdata <= pre_d_reg[15:8];
          OFS_PRE_D_LOW:  reg_rdata <= pre_d_reg[7:0];
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // channel status copy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_cs_valid <= 1'b0;
      tx_cs_bit   <= 1'b0;
    end else begin
      tx_cs_valid <= rx_cs_valid && channel_status_auto_copy_reg;
      tx_cs_bit   <= rx_cs_bit && channel_status_auto_copy_reg;
    end
  end

  // user bit path
  // bits offered while copy is off are accepted and dropped; ready only falls on a full buffer
  sab_fifo #(
    .WIDTH (UB_WIDTH),
    .DEPTH (UB_DEPTH)
  ) u_user_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_user_valid && user_bit_auto_copy_reg),
    .in_ready  (rx_user_ready),
    .in_data   ({rx_msg_start, rx_unit_start, rx_user_bit}),
    .out_valid (ub_out_valid),
    .out_ready (ub_out_ready),
    .out_data  (ub_out_data)
  );

  assign msg_gap      = {message_gap_high_reg, message_gap_low_reg};
  assign units_active = unit_stuffing_enable_reg && (tx_user_buffer_mode == MODE_UNITS);
  assign needs_gap    = ub_out_valid && !head_gapped_reg
                        && (ub_out_data[2] || (ub_out_data[1] && units_active));
  assign load_val     = ub_out_data[2] ? msg_gap : {12'h000, unit_gap_limit_reg};
  assign ub_out_ready = user_bit_auto_copy_reg && tx_user_req && (state_reg == SAB_ST_DATA)
                        && (!needs_gap || load_val == 16'h0000);

  // each transmitter request while user-bit copy is set is answered with one bit: gap zero, data, or filler zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg       <= SAB_ST_DATA;
      gap_cnt_reg     <= '0;
      head_gapped_reg <= 1'b0;
      tx_user_valid   <= 1'b0;
      tx_user_bit     <= 1'b0;
    end else begin
      tx_user_valid <= tx_user_req && user_bit_auto_copy_reg;
      tx_user_bit   <= 1'b0;
      if (tx_user_req && user_bit_auto_copy_reg) begin
        case (state_reg)
          SAB_ST_GAP: begin
            gap_cnt_reg <= gap_cnt_reg - 16'h0001;
            if (gap_cnt_reg == 16'h0001) begin
              state_reg <= SAB_ST_DATA;
            end
          end
          SAB_ST_DATA: begin
            if (needs_gap && load_val != 16'h0000) begin
              head_gapped_reg <= 1'b1;
              gap_cnt_reg     <= load_val - 16'h0001;
              if (load_val != 16'h0001) begin
                state_reg <= SAB_ST_GAP;
              end
            end else if (ub_out_valid) begin
              head_gapped_reg <= 1'b0;
              tx_user_bit     <= ub_out_data[0];
            end
          end
          default: state_reg <= SAB_ST_DATA;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_gap_reset_value: assert property (
    !$past(rst_n) |-> (message_gap_high_reg == RST_GAP_HIGH && message_gap_low_reg == RST_GAP_LOW))
    else $error("message gap not at reset value");

  chk_msg_gap_load: assert property (
    (tx_user_req && user_bit_auto_copy_reg && state_reg == SAB_ST_DATA && needs_gap
     && ub_out_data[2] && msg_gap > 16'h0001)
    |=> (state_reg == SAB_ST_GAP && gap_cnt_reg == $past(msg_gap) - 16'h0001))
    else $error("message gap not loaded from gap bytes");

  chk_unit_no_stuff: assert property (
    (tx_user_req && user_bit_auto_copy_reg && state_reg == SAB_ST_DATA && !units_active
     && ub_out_valid && !ub_out_data[2])
    |=> (tx_user_valid && tx_user_bit == $past(ub_out_data[0])))
    else $error("unit gap inserted while stuffing disabled");

  chk_unit_gap_load: assert property (
    (tx_user_req && user_bit_auto_copy_reg && state_reg == SAB_ST_DATA && needs_gap
     && !ub_out_data[2] && unit_gap_limit_reg > 4'h1)
    |=> (state_reg == SAB_ST_GAP
         && gap_cnt_reg == {12'h000, $past(unit_gap_limit_reg)} - 16'h0001))
    else $error("unit gap not loaded from limit");

  chk_user_copy_off: assert property (
    !user_bit_auto_copy_reg |-> (!ub_out_ready ##1 !tx_user_valid))
    else $error("user bits moved while copy disabled");

  chk_cs_copy: assert property (
    (rx_cs_valid && channel_status_auto_copy_reg) |=> (tx_cs_valid && tx_cs_bit == $past(rx_cs_bit)))
    else $error("channel status bit not copied");

  chk_limit_range: assert property (
    reg_wr && reg_addr == OFS_AUTO_COPY |=> unit_gap_limit_reg <= LIMIT_MAX)
    else $error("unit gap limit above eight");

  chk_ratio_track: assert property (
    ##1 (ratio_reg == $past(converter_ratio)))
    else $error("ratio register not following measurement");

  chk_pre_zero: assert property (
    !nonaudio_present |=> (pre_c_reg == 16'h0000 && pre_d_reg == 16'h0000))
    else $error("preamble not zero without nonaudio");

  chk_pre_capture: assert property (
    (burst_detect && nonaudio_present) |=> pre_c_reg == $past(burst_pre_c))
    else $error("preamble c not captured");

  chk_pre_d_capture: assert property (
    (burst_detect && nonaudio_present && !subframe_nonaudio)
    |=> pre_d_reg == $past(burst_pre_d))
    else $error("preamble d not captured");

  chk_pre_d_source: assert property (
    (burst_detect && nonaudio_present && subframe_nonaudio) |=> pre_d_reg == $past(burst_pre_c_b))
    else $error("channel b preamble c not in d pair");

endmodule // sab_regs

`default_nettype wire

/* File: include/sab_pkg.sv */
// shared constants for the auto-copy and status register bank
package sab_pkg;
  // register offsets
  localparam logic [6:0] OFS_GAP_HIGH   = 7'h0F;
  localparam logic [6:0] OFS_GAP_LOW    = 7'h10;
  localparam logic [6:0] OFS_AUTO_COPY  = 7'h11;
  localparam logic [6:0] OFS_RATIO_HIGH = 7'h12;
  localparam logic [6:0] OFS_RATIO_LOW  = 7'h13;
  localparam logic [6:0] OFS_PRE_C_HIGH = 7'h14;
  localparam logic [6:0] OFS_PRE_C_LOW  = 7'h15;
  localparam logic [6:0] OFS_PRE_D_HIGH = 7'h16;
  localparam logic [6:0] OFS_PRE_D_LOW  = 7'h17;
  // reset values
  localparam logic [7:0] RST_GAP_HIGH   = 8'h00;
  localparam logic [7:0] RST_GAP_LOW    = 8'h09;
  localparam logic [7:0] RST_AUTO_COPY  = 8'h00;
  // auto-copy control field positions
  localparam int BIT_UNIT_STUFF  = 6;
  localparam int BIT_USER_COPY   = 5;
  localparam int BIT_CS_COPY     = 4;
  localparam int LIMIT_MSB       = 3;
  localparam logic [3:0] LIMIT_MAX = 4'h8;
  // transmit user-buffer mode carrying information units
  localparam logic [1:0] MODE_UNITS = 2'h2;
  // user-bit buffer shape: {message start, unit start, bit}
  localparam int UB_WIDTH = 3;
  localparam int UB_DEPTH = 8;
  typedef enum logic [0:0] {
    SAB_ST_DATA,
    SAB_ST_GAP
  } sab_state_e;
endpackage : sab_pkg

/* File: sim/tb_sab_regs.sv */
// self-checking bench for the auto-copy and status register bank
`timescale 1ns/10ps
`default_nettype none
module tb_sab_regs
  import sab_pkg::*;
;
  localparam int WATCHDOG_CYCLES = 20000;
  logic        ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, w;
  logic [1:0]  tx_user_buffer_mode;
  logic        rx_user_valid, rx_user_ready, rx_user_bit, rx_msg_start, rx_unit_start;
  logic        tx_user_req, tx_user_valid, tx_user_bit;
  logic        rx_cs_valid, rx_cs_bit, tx_cs_valid, tx_cs_bit;
  logic [14:0] converter_ratio;
  logic        nonaudio_present, burst_detect, subframe_nonaudio;
  logic [15:0] burst_pre_c, burst_pre_d, burst_pre_c_b, lfsr_q, rv;
  logic        fill_q[$];
  int          errors, checks, n;

  sab_regs u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .tx_user_buffer_mode(tx_user_buffer_mode), .rx_user_valid(rx_user_valid),
    .rx_user_ready(rx_user_ready), .rx_user_bit(rx_user_bit), .rx_msg_start(rx_msg_start),
    .rx_unit_start(rx_unit_start), .tx_user_req(tx_user_req), .tx_user_valid(tx_user_valid),
    .tx_user_bit(tx_user_bit), .rx_cs_valid(rx_cs_valid), .rx_cs_bit(rx_cs_bit),
    .tx_cs_valid(tx_cs_valid), .tx_cs_bit(tx_cs_bit), .converter_ratio(converter_ratio),
    .nonaudio_present(nonaudio_present), .burst_detect(burst_detect),
    .subframe_nonaudio(subframe_nonaudio), .burst_pre_c(burst_pre_c),
    .burst_pre_d(burst_pre_d), .burst_pre_c_b(burst_pre_c_b)
  );

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  // limits above eight read back clamped, reserved bit 7 reads zero
  function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
    return {1'b0, d[6:4], (d[3:0] > LIMIT_MAX) ? LIMIT_MAX : d[3:0]};
  endfunction

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask
  // all drivers are entered and left at a falling edge
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // idle edge so a following call never re-raises the strobe in the same step
    @(negedge ref_clk);
  endtask
  task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
    int i;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge ref_clk);
    chk_bit("reg_rvalid", 1'b1, reg_rvalid);
    chk_byte($sformatf("reg_rdata at %h", a), exp, reg_rdata);
    @(negedge ref_clk);
  endtask
  task automatic push(input logic b, input logic ms, input logic us);
    chk_bit("rx_user_ready", 1'b1, rx_user_ready);
    rx_user_bit = b;
    rx_msg_start = ms;
    rx_unit_start = us;
    rx_user_valid = 1'b1;
    @(negedge ref_clk);
  endtask
  // request stays high between calls so requests run back to back
  task automatic user_req(input logic en, input logic exp_bit);
    tx_user_req = 1'b1;
    @(negedge ref_clk);
    chk_bit("tx_user_valid", en, tx_user_valid);
    if (en) chk_bit("tx_user_bit", exp_bit, tx_user_bit);
  endtask
  task automatic expect_seq(input int zeros, input logic last);
    for (int i = 0; i < zeros; i++) user_req(1'b1, 1'b0);
    user_req(1'b1, last);
    tx_user_req = 1'b0;
  endtask
  task automatic test_end(input string name);
    $display("test %s done, checks %0d errors %0d", name, checks, errors);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #(WATCHDOG_CYCLES * 10);
    errors++;
    give_verdict();
  end

  initial begin
    lfsr_q = 16'h001E;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, tx_user_buffer_mode} = '0;
    {rx_user_valid, rx_user_bit, rx_msg_start, rx_unit_start, tx_user_req} = '0;
    {rx_cs_valid, rx_cs_bit, nonaudio_present, burst_detect, subframe_nonaudio} = '0;
    {converter_ratio, burst_pre_c, burst_pre_d, burst_pre_c_b} = '0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    reg_read(OFS_GAP_HIGH, RST_GAP_HIGH);
    reg_read(OFS_GAP_LOW, RST_GAP_LOW);
    reg_read(OFS_AUTO_COPY, RST_AUTO_COPY);
    for (int a = 20; a < 24; a++) reg_read(a[6:0], 8'h00);
    reg_read(7'h7F, 8'h00);
    test_end("reset");
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      w = (i == 0) ? 8'h6F : (i == 1) ? 8'h88 : rv[7:0];
      reg_write(OFS_AUTO_COPY, w);
      reg_read(OFS_AUTO_COPY, exp_ctrl(w));
      reg_write(OFS_GAP_HIGH, rv[15:8]);
      reg_read(OFS_GAP_HIGH, rv[15:8]);
    end
    test_end("control");
    rv = rnd();
    converter_ratio = rv[14:0];
    repeat (2) @(negedge ref_clk);
    reg_write(OFS_RATIO_HIGH, 8'hFF);
    reg_read(OFS_RATIO_HIGH, {1'b0, rv[14:8]});
    reg_read(OFS_RATIO_LOW, rv[7:0]);
    nonaudio_present = 1'b1;
    burst_pre_c = rnd();
    burst_pre_d = rnd();
    burst_pre_c_b = rnd();
    burst_detect = 1'b1;
    @(negedge ref_clk);
    burst_detect = 1'b0;
    reg_write(OFS_PRE_C_HIGH, 8'h5A);
    reg_read(OFS_PRE_C_HIGH, burst_pre_c[15:8]);
    reg_read(OFS_PRE_C_LOW, burst_pre_c[7:0]);
    reg_read(OFS_PRE_D_HIGH, burst_pre_d[15:8]);
    reg_read(OFS_PRE_D_LOW, burst_pre_d[7:0]);
    subframe_nonaudio = 1'b1;
    burst_detect = 1'b1;
    @(negedge ref_clk);
    burst_detect = 1'b0;
    reg_read(OFS_PRE_D_HIGH, burst_pre_c_b[15:8]);
    reg_read(OFS_PRE_D_LOW, burst_pre_c_b[7:0]);
    nonaudio_present = 1'b0;
    repeat (2) @(negedge ref_clk);
    reg_read(OFS_PRE_C_LOW, 8'h00);
    reg_read(OFS_PRE_D_HIGH, 8'h00);
    test_end("status");
    reg_write(OFS_GAP_HIGH, 8'h00);
    reg_write(OFS_AUTO_COPY, 8'h20);
    n = 0;
    while (rx_user_ready === 1'b1 && n < 12) begin
      rv = rnd();
      fill_q.push_back(rv[0]);
      push(rv[0], 1'b0, 1'b0);
      n++;
    end
    rx_user_valid = 1'b0;
    chk_byte("fifo depth", UB_DEPTH[7:0], n[7:0]);
    foreach (fill_q[i]) user_req(1'b1, fill_q[i]);
    expect_seq(0, 1'b0);
    reg_write(OFS_GAP_LOW, RST_GAP_LOW);
    push(1'b1, 1'b1, 1'b0);
    rx_user_valid = 1'b0;
    expect_seq(9, 1'b1);
    rv = rnd();
    reg_write(OFS_GAP_HIGH, 8'h01);
    reg_write(OFS_GAP_LOW, rv[7:0]);
    push(1'b1, 1'b1, 1'b1);
    rx_user_valid = 1'b0;
    expect_seq(256 + rv[7:0], 1'b1);
    test_end("message gap");
    reg_write(OFS_GAP_HIGH, 8'h00);
    reg_write(OFS_GAP_LOW, 8'h00);
    reg_write(OFS_AUTO_COPY, 8'h6B);
    for (int m = 0; m < 4; m++) begin
      tx_user_buffer_mode = m[1:0];
      push(1'b1, 1'b0, 1'b1);
      rx_user_valid = 1'b0;
      expect_seq((m[1:0] == MODE_UNITS) ? 8 : 0, 1'b1);
    end
    tx_user_buffer_mode = MODE_UNITS;
    reg_write(OFS_AUTO_COPY, 8'h23);
    push(1'b1, 1'b0, 1'b1);
    rx_user_valid = 1'b0;
    expect_seq(0, 1'b1);
    test_end("unit stuffing");
    reg_write(OFS_AUTO_COPY, 8'h10);
    push(1'b1, 1'b0, 1'b0);
    rx_user_valid = 1'b0;
    user_req(1'b0, 1'b0);
    tx_user_req = 1'b0;
    reg_write(OFS_AUTO_COPY, 8'h20);
    expect_seq(0, 1'b0);
    for (int e = 1; e >= 0; e--) begin
      reg_write(OFS_AUTO_COPY, e[0] ? 8'h10 : 8'h00);
      rx_cs_valid = 1'b1;
      rx_cs_bit = 1'b1;
      @(negedge ref_clk);
      rx_cs_valid = 1'b0;
      chk_bit("tx_cs_valid", e[0], tx_cs_valid);
      chk_bit("tx_cs_bit", e[0], tx_cs_bit);
    end
    test_end("channel status");
    give_verdict();
  end
endmodule // tb_sab_regs
`default_nettype wire
